// ---- src/sc_pkg.sv ----
package sc_pkg;
  // instruction opcodes and subcommands
  localparam logic [7:0] OP_SEC_IN  = 8'h9B;
  localparam logic [7:0] OP_SEC_OUT = 8'h96;
  localparam logic [7:0] OP_RST_EN  = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  localparam logic [7:0] SUB_ROOT   = 8'h00;
  localparam logic [7:0] SUB_SESS   = 8'h01;
  localparam logic [7:0] SUB_INC    = 8'h02;
  localparam logic [7:0] SUB_REQ    = 8'h03;
  // widths
  localparam int MSG_W  = 32'h200;
  localparam int KEY_W  = 32'h100;
  localparam int CNT_W  = 32'h20;
  localparam int TAG_W  = 32'h60;
  localparam int TSIG_W = 32'hE0;
  // frame lengths in bytes, opcode included
  localparam logic [6:0] MSG_BYTES  = 7'h40;
  localparam logic [6:0] LEN_ROOT   = MSG_BYTES;
  localparam logic [6:0] LEN_SESS   = 7'h28;
  localparam logic [6:0] LEN_INC    = LEN_SESS;
  localparam logic [6:0] LEN_REQ    = 7'h30;
  localparam logic [6:0] SIG_FULL   = 7'h20;
  localparam logic [6:0] SIG_TRUNC  = 7'h1C;
  localparam logic [6:0] SLOT_BYTE  = 7'h02;
  localparam logic [6:0] DATA_BYTE  = 7'h04;
  localparam logic [6:0] MIN_REPORT = 7'h02;
  localparam logic [6:0] CNT_SAT    = 7'h7F;
  // output frame byte positions
  localparam logic [6:0] OUT_FIRST  = 7'h01;
  localparam logic [6:0] OUT_STATUS = 7'h02;
  localparam logic [6:0] OUT_TAG    = 7'h03;
  localparam logic [6:0] OUT_CNT    = 7'h0F;
  localparam logic [6:0] OUT_SIG    = 7'h13;
  localparam logic [6:0] OUT_LAST   = 7'h32;
  // status byte values
  localparam logic [7:0] ST_RESET   = 8'h00;
  localparam logic [7:0] ST_BUSY    = 8'h01;
  localparam logic [7:0] ST_KEYERR  = 8'h02;
  localparam logic [7:0] ST_SIG_ERR = 8'h04;
  localparam logic [7:0] ST_UNINIT  = 8'h08;
  localparam logic [7:0] ST_CNT_ERR = 8'h10;
  localparam logic [7:0] ST_OK      = 8'h80;

  typedef struct packed {
    logic [KEY_W-1:0] key;
    logic [MSG_W-1:0] msg;
    logic [6:0]       len;
  } hash_req_t;
endpackage

// ---- src/byte_fifo.sv ----
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [DEPTH-1:0][WIDTH-1:0] mem_q, mem_d;
  logic [AW-1:0]               wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]                 cnt_q, cnt_d;
  logic                        push, pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // depth must be a power of two: pointers wrap by overflow
  always_comb
  begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
      wr_d        = wr_q + 1'b1;
    end
    if (pop)
      rd_d = rd_q + 1'b1;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush)
    begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      mem_q <= '0;
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
endmodule

// ---- src/secure_counter_unit.sv ----
`timescale 1ns/1ps
// Overview of operation
// RULE1: chip select high: ignore input and release every data pin.
// RULE2: nothing accepted until a chip select falling edge after reset.
// RULE3: input bits are sampled on rising serial clock edges.
// RULE4: output bits are shifted out on falling serial clock edges.
// RULE5: io lines are two-way; this unit drives only the single output line.
// RULE6: four 32-bit counters, chosen by a signed 8-bit slot byte; the code compares it unsigned and rejects values 4 to 255.
// RULE7: four permanent root keys and four volatile session keys, one per slot.
// RULE8: authentication uses keyed double SHA-256 hashing, 256-bit result.
// RULE9: recompute keyed hash, compare with signature, record outcome in status.
// RULE10: accepted root write stores key for good and zeroes its counter.
// RULE11: initialized root key never changes and is never sent out.
// RULE12: host loads each session key after power-up before other operations.
// RULE13: accepted increment raises the selected counter by exactly one.
// RULE14: accepted request exposes counter value through the output command.
// RULE15: accepted input command sets busy bit until its operation ends.
// RULE16: operation cannot be suspended; only enable-reset then reset aborts it.
// RULE17: ordinary flash commands keep running while authentication is busy.
// RULE18: input command arriving while busy is ignored entirely.
// RULE19: status readable while busy; later bytes then invalid for the host.
// RULE20: software reset works anytime and clears all volatile state.
// RULE21: authentication frames are single-bit, eight clocks per byte.
// RULE22: host sends the reserved byte as all zeros.
// RULE23: error-free completion leaves status at only the top bit set.
// RULE24: status untouched until the command's first bytes have arrived.
// RULE25: failed signature changes nothing and reports a mismatch.
// RULE26: frame cut short by chip select aborts without any change; the code sets status to ST_SIG_ERR once two bytes have arrived.
module secure_counter_unit #(
  parameter int SLOTS = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         sclk,
  input  wire logic         cs_n,
  input  wire logic [3:0]   io_i,
  output logic      [3:0]   io_o,
  output logic      [3:0]   io_oe,
  output logic              sec_busy,
  output logic              hash_valid,
  output sc_pkg::hash_req_t hash_cmd,
  input  wire logic         hash_done,
  input  wire logic [255:0] hash_digest
);
  localparam int SW = $clog2(SLOTS);
  localparam int MW = sc_pkg::MSG_W;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage 0 feeds only stage 1
  logic [2:0] sclk_q, cs_q;
  logic [1:0] din_q;
  logic       rise, fall, cs_lo, cs_fall, cs_rise;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      sclk_q <= '0;
      cs_q   <= 3'h7;
      din_q  <= '0;
    end
    else if (ce)
    begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q   <= {cs_q[1:0], cs_n};
      din_q  <= {din_q[0], io_i[0]};
    end

  assign rise    = sclk_q[1] & ~sclk_q[2];
  assign fall    = ~sclk_q[1] & sclk_q[2];
  assign cs_lo   = ~cs_q[1];
  assign cs_fall = cs_q[2] & ~cs_q[1];
  assign cs_rise = ~cs_q[2] & cs_q[1];

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] byte_at(input logic [MW-1:0] m, input logic [6:0] n);
    byte_at = m[MW-1-8*n -: 8];
  endfunction

  function automatic logic [6:0] frame_len(input logic [7:0] sub);
    case (sub)
      sc_pkg::SUB_ROOT: frame_len = sc_pkg::LEN_ROOT;
      sc_pkg::SUB_SESS: frame_len = sc_pkg::LEN_SESS;
      sc_pkg::SUB_INC:  frame_len = sc_pkg::LEN_INC;
      sc_pkg::SUB_REQ:  frame_len = sc_pkg::LEN_REQ;
      default:          frame_len = 7'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic                   seen_q, seen_d, ign_q, ign_d, arm_q, arm_d;
  logic                   busy_q, busy_d, hreq_q, hreq_d, oe_q, oe_d;
  logic [2:0]             bit_q, bit_d;
  logic [6:0]             bcnt_q, bcnt_d, idx_q, idx_d, flen, slen;
  logic [7:0]             sh_q, sh_d, op_q, op_d, st_q, st_d, tx_q, tx_d;
  logic [MW-1:0]          msg_q, msg_d;
  sc_pkg::hash_req_t      hcmd_q, hcmd_d;
  logic [SLOTS-1:0][255:0] root_q, root_d, sess_q, sess_d;
  logic [SLOTS-1:0][31:0] cnt_q, cnt_d;
  logic [SLOTS-1:0]       root_ok_q, root_ok_d, sess_ok_q, sess_ok_d;
  logic [95:0]            tag_q, tag_d;
  logic [31:0]            ocnt_q, ocnt_d;
  logic [255:0]           osig_q, osig_d, mkey;
  logic [7:0]             bval, sub, slot_b, pbyte;
  logic [SW-1:0]          slot;
  logic                   bdone, soft_w, start_w, done_w, sig_ok;
  logic                   inc_w, root_wr_w, out_frame, push, pop;
  logic                   f_ready, f_valid;
  logic [7:0]             f_data;

  assign sub    = byte_at(msg_q, 7'h01);
  assign slot_b = byte_at(msg_q, sc_pkg::SLOT_BYTE);
  assign slot   = slot_b[SW-1:0];
  assign flen   = frame_len(sub);
  assign slen   = (sub == sc_pkg::SUB_ROOT) ? sc_pkg::SIG_TRUNC : sc_pkg::SIG_FULL;
  assign mkey   = msg_q[MW-1-8*sc_pkg::DATA_BYTE -: 256];

  always_comb
  begin
    seen_d    = seen_q;
    ign_d     = ign_q;
    arm_d     = arm_q;
    busy_d    = busy_q;
    hreq_d    = hreq_q;
    oe_d      = oe_q;
    bit_d     = bit_q;
    bcnt_d    = bcnt_q;
    idx_d     = idx_q;
    sh_d      = sh_q;
    op_d      = op_q;
    st_d      = st_q;
    tx_d      = tx_q;
    msg_d     = msg_q;
    hcmd_d    = hcmd_q;
    root_d    = root_q;
    sess_d    = sess_q;
    cnt_d     = cnt_q;
    root_ok_d = root_ok_q;
    sess_ok_d = sess_ok_q;
    tag_d     = tag_q;
    ocnt_d    = ocnt_q;
    osig_d    = osig_q;
    bval      = {sh_q[6:0], din_q[1]};
    bdone     = 1'b0;
    soft_w    = 1'b0;
    start_w   = 1'b0;
    inc_w     = 1'b0;
    root_wr_w = 1'b0;
    pop       = 1'b0;
    done_w    = hreq_q && hash_done;
    // the device owns the hash check; the engine only hashes
    if (sub == sc_pkg::SUB_ROOT)
      sig_ok = msg_q[MW-1-8*(flen-slen) -: sc_pkg::TSIG_W] ==
               hash_digest[255 -: sc_pkg::TSIG_W];
    else
      sig_ok = msg_q[MW-1-8*(flen-slen) -: 256] == hash_digest;
    if (cs_fall)
      seen_d = 1'b1;                                           // [RULE2]
    if (cs_lo && seen_q && rise)
    begin
      sh_d  = bval;                                            // [RULE3]
      bit_d = bit_q + 3'h1;
      bdone = bit_q == 3'h7;                                   // [RULE21]
    end
    if (bdone)
    begin
      if (bcnt_q == 7'h00)
      begin
        op_d   = bval;
        ign_d  = (bval == sc_pkg::OP_SEC_IN) && busy_q;       // [RULE18]
        soft_w = (bval == sc_pkg::OP_RST) && arm_q;           // [RULE16]
        arm_d  = bval == sc_pkg::OP_RST_EN;
      end
      // a running operation keeps its captured frame
      if (!busy_q && bcnt_q < sc_pkg::MSG_BYTES)
        msg_d[MW-1-8*bcnt_q -: 8] = bval;
      if (bcnt_q != sc_pkg::CNT_SAT)
        bcnt_d = bcnt_q + 7'h01;
    end
    if (cs_rise)
    begin
      bit_d  = 3'h0;
      bcnt_d = 7'h00;
      op_d   = 8'h00;
      ign_d  = 1'b0;
      if (op_q == sc_pkg::OP_SEC_IN && !ign_q && !busy_q)
      begin
        if (bcnt_q == flen && flen != 7'h00)
          start_w = 1'b1;
        else if (bcnt_q >= sc_pkg::MIN_REPORT)
          st_d = sc_pkg::ST_SIG_ERR;                           // [RULE24] [RULE26]
      end
    end
    if (start_w)
    begin
      if (slot_b >= SLOTS)
        st_d = sc_pkg::ST_SIG_ERR;                             // [RULE6]
      else if (sub == sc_pkg::SUB_ROOT && root_ok_q[slot])
        st_d = sc_pkg::ST_KEYERR;                              // [RULE11]
      else if (sub == sc_pkg::SUB_SESS && !root_ok_q[slot])
        st_d = sc_pkg::ST_KEYERR;
      else if (sub != sc_pkg::SUB_ROOT && sub != sc_pkg::SUB_SESS && !sess_ok_q[slot])
        st_d = sc_pkg::ST_UNINIT;
      else
      begin
        busy_d     = 1'b1;                                     // [RULE15]
        st_d       = sc_pkg::ST_BUSY;
        hreq_d     = 1'b1;                                     // [RULE8]
        hcmd_d.msg = msg_q;
        hcmd_d.len = flen - slen;
        if (sub == sc_pkg::SUB_ROOT)
          hcmd_d.key = mkey;
        else if (sub == sc_pkg::SUB_SESS)
          hcmd_d.key = root_q[slot];                           // [RULE7]
        else
          hcmd_d.key = sess_q[slot];
      end
    end
    if (done_w)
    begin
      hreq_d = 1'b0;
      busy_d = 1'b0;
      st_d   = sc_pkg::ST_OK;                                  // [RULE23]
      if (!sig_ok)
        st_d = sc_pkg::ST_SIG_ERR;                             // [RULE9] [RULE25]
      else
      begin
        case (sub)
          sc_pkg::SUB_ROOT:
          begin
            root_wr_w       = 1'b1;
            root_d[slot]    = mkey;                            // [RULE10]
            root_ok_d[slot] = 1'b1;
            cnt_d[slot]     = '0;
          end
          sc_pkg::SUB_SESS:
          begin
            sess_d[slot]    = hash_digest;
            sess_ok_d[slot] = 1'b1;
          end
          sc_pkg::SUB_INC:
            if (mkey[255 -: 32] != cnt_q[slot])
              st_d = sc_pkg::ST_CNT_ERR;
            else
            begin
              inc_w       = 1'b1;
              cnt_d[slot] = cnt_q[slot] + 32'h1;               // [RULE13]
            end
          default:
          begin
            tag_d  = mkey[255 -: 96];                          // [RULE14]
            ocnt_d = cnt_q[slot];
            osig_d = hash_digest;
          end
        endcase
      end
    end
    if (soft_w)
    begin
      busy_d    = 1'b0;                                        // [RULE20]
      hreq_d    = 1'b0;
      st_d      = sc_pkg::ST_RESET;
      sess_d    = '0;
      sess_ok_d = '0;
      tag_d     = '0;
      ocnt_d    = '0;
      osig_d    = '0;
      arm_d     = 1'b0;
    end
    // output frame: the builder refills the fifo ahead of the shifter
    out_frame = cs_lo && op_q == sc_pkg::OP_SEC_OUT && bcnt_q != 7'h00;
    push      = out_frame && idx_q <= sc_pkg::OUT_LAST;
    if (idx_q == sc_pkg::OUT_STATUS)
      pbyte = st_q;                                            // [RULE19]
    else if (idx_q >= sc_pkg::OUT_SIG && idx_q <= sc_pkg::OUT_LAST)
      pbyte = osig_q[255-8*(idx_q-sc_pkg::OUT_SIG) -: 8];
    else if (idx_q >= sc_pkg::OUT_CNT && idx_q < sc_pkg::OUT_SIG)
      pbyte = ocnt_q[31-8*(idx_q-sc_pkg::OUT_CNT) -: 8];
    else if (idx_q >= sc_pkg::OUT_TAG && idx_q < sc_pkg::OUT_CNT)
      pbyte = tag_q[95-8*(idx_q-sc_pkg::OUT_TAG) -: 8];
    else
      pbyte = 8'h00;
    if (!out_frame)
      idx_d = sc_pkg::OUT_FIRST;
    else if (push && f_ready)
      idx_d = idx_q + 7'h01;
    if (!cs_lo)
      oe_d = 1'b0;                                             // [RULE1]
    else if (fall && op_q == sc_pkg::OP_SEC_OUT && bcnt_q != 7'h00)
    begin
      if (bit_q == 3'h0)
      begin
        pop  = 1'b1;
        tx_d = f_valid ? f_data : 8'h00;                       // [RULE4]
        oe_d = 1'b1;
      end
      else
        tx_d = {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      seen_q    <= 1'b0;
      ign_q     <= 1'b0;
      arm_q     <= 1'b0;
      busy_q    <= 1'b0;
      hreq_q    <= 1'b0;
      oe_q      <= 1'b0;
      bit_q     <= '0;
      bcnt_q    <= '0;
      idx_q     <= sc_pkg::OUT_FIRST;
      sh_q      <= '0;
      op_q      <= '0;
      st_q      <= sc_pkg::ST_RESET;
      tx_q      <= '0;
      msg_q     <= '0;
      hcmd_q    <= '0;
      root_q    <= '0;
      sess_q    <= '0;
      cnt_q     <= '0;
      root_ok_q <= '0;
      sess_ok_q <= '0;
      tag_q     <= '0;
      ocnt_q    <= '0;
      osig_q    <= '0;
    end
    else if (ce)
    begin
      seen_q    <= seen_d;
      ign_q     <= ign_d;
      arm_q     <= arm_d;
      busy_q    <= busy_d;
      hreq_q    <= hreq_d;
      oe_q      <= oe_d;
      bit_q     <= bit_d;
      bcnt_q    <= bcnt_d;
      idx_q     <= idx_d;
      sh_q      <= sh_d;
      op_q      <= op_d;
      st_q      <= st_d;
      tx_q      <= tx_d;
      msg_q     <= msg_d;
      hcmd_q    <= hcmd_d;
      root_q    <= root_d;
      sess_q    <= sess_d;
      cnt_q     <= cnt_d;
      root_ok_q <= root_ok_d;
      sess_ok_q <= sess_ok_d;
      tag_q     <= tag_d;
      ocnt_q    <= ocnt_d;
      osig_q    <= osig_d;
    end

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (4)
  ) u_out_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .flush     (!out_frame),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (pbyte),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  // only the single output line is ever driven; flash array paths live elsewhere
  assign io_o       = {2'b00, tx_q[7], 1'b0};                 // [RULE5]
  assign io_oe      = {2'b00, oe_q & cs_lo, 1'b0};
  assign sec_busy   = busy_q;                                  // [RULE17]
  assign hash_valid = hreq_q;
  assign hash_cmd   = hcmd_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_start;
    ce && start_w && busy_d;
  endsequence
  sequence s_good_done;
    ce && done_w && sig_ok && !soft_w;
  endsequence

  a_release_deselect: assert property (ce && !cs_lo |-> io_oe == 4'h0 ##1 !oe_q) // [RULE1]
    else $error("data pin driven while deselected");
  a_wait_first_fall: assert property (!seen_q |-> bcnt_q == 7'h00 && bit_q == 3'h0) // [RULE2]
    else $error("bits taken before first chip select fall");
  a_sample_rise: assert property (ce && cs_lo && seen_q && rise |=>   // [RULE3]
    bit_q == $past(bit_q) + 3'h1)
    else $error("bit count not advanced on rising edge");
  a_drive_fall: assert property (ce && !fall |=> $stable(tx_q))      // [RULE4]
    else $error("output changed away from falling edge");
  a_busy_set: assert property (s_start |=> busy_q && st_q == sc_pkg::ST_BUSY) // [RULE15]
    else $error("busy not shown after start");
  a_busy_hold: assert property (ce && busy_q && !done_w && !soft_w |=> busy_q) // [RULE16]
    else $error("operation ended without result or reset");
  a_ignore_busy: assert property (ce && bdone && bcnt_q == 7'h00 && // [RULE18]
    bval == sc_pkg::OP_SEC_IN && busy_q |=> ign_q ##0 !start_w)
    else $error("input command not ignored while busy");
  a_incr_one: assert property ((s_good_done and inc_w) |=>          // [RULE13]
    cnt_q[$past(slot)] == $past(cnt_q[slot]) + 32'h1)
    else $error("counter not raised by one");
  a_root_locked: assert property (ce && root_wr_w |-> !root_ok_q[slot]) // [RULE11]
    else $error("initialized root key rewritten");
  a_root_zero: assert property ((s_good_done and root_wr_w) |=>     // [RULE10]
    cnt_q[$past(slot)] == 32'h0 && root_ok_q[$past(slot)])
    else $error("root write did not zero its counter");
  a_ok_status: assert property ((s_good_done and sub != sc_pkg::SUB_INC) |=> // [RULE23]
    st_q == sc_pkg::ST_OK)
    else $error("success status wrong");
  a_bad_sig: assert property (ce && done_w && !sig_ok && !soft_w |=> // [RULE25]
    st_q == sc_pkg::ST_SIG_ERR && $stable(cnt_q) && $stable(root_q))
    else $error("failed signature changed state");
  a_short_frame: assert property (ce && cs_rise && bcnt_q != flen |-> !start_w) // [RULE26]
    else $error("short frame started an operation");
  a_soft_clear: assert property (ce && soft_w |=>                   // [RULE20]
    !busy_q && sess_ok_q == '0 && st_q == sc_pkg::ST_RESET)
    else $error("software reset left volatile state");
endmodule

// ---- tb/spi_host.sv ----
`timescale 1ns/1ps
////////////////////////////////////////
module spi_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  logic [7:0] tx [64];
  logic [7:0] rx [64];

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  ////////////////////////////////////////
  // mode 0, msb first; the serial clock stands still outside frames
  task automatic frame(input int n);
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++)
    begin
      for (int b = 7; b >= 0; b--)
      begin
        mosi = tx[i][b];
        #62.5 sclk = 1'b1;
        rx[i][b] = miso;
        #62.5 sclk = 1'b0;
      end
    end
    // released line shows the inverse so a stale bit never passes as data
    mosi = ~mosi;
    #100 cs_n = 1'b1;
    #200;
  endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
////////////////////////////////////////
module tb;
  typedef struct packed {
    logic [7:0]  sub;
    logic [7:0]  slot;
    logic [31:0] dat;
    logic        good;
    logic [7:0]  st;
  } row_t;
  logic              clk;
  logic              rstn;
  logic              sclk;
  logic              cs_n;
  logic              mosi;
  logic              miso;
  logic              hash_done;
  logic              stall;
  logic              sec_busy;
  logic              hash_valid;
  logic [3:0]        io_o;
  logic [3:0]        io_oe;
  logic [3:0]        io_i;
  logic [2:0]        wt;
  logic [255:0]      hash_digest;
  logic [255:0]      kr;
  logic [255:0]      ks;
  logic [255:0]      sg;
  sc_pkg::hash_req_t hash_cmd;
  row_t              rows [11];
  int                failures;
  int                total_checks;
  int                cyc;

  // stand-in keyed hash: cheap, but depends on key and the frame head
  function automatic logic [255:0] fk(input logic [255:0] k, input logic [63:0] m);
    return {4{k[255:192] ^ m}};
  endfunction

  assign io_i = {io_o[3:1] & io_oe[3:1], mosi};
  assign miso = io_oe[1] ? io_o[1] : 1'bz;
  assign hash_digest = fk(hash_cmd.key, hash_cmd.msg[511:448]);

  secure_counter_unit i_dut (
    .clk(clk), .rstn(rstn), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .io_i(io_i),
    .io_o(io_o), .io_oe(io_oe), .sec_busy(sec_busy), .hash_valid(hash_valid),
    .hash_cmd(hash_cmd), .hash_done(hash_done), .hash_digest(hash_digest)
  );
  spi_host i_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////
  // hash engine answers after five cycles unless stalled
  always @(posedge clk)
  begin
    hash_done <= 1'b0;
    if (hash_valid && !hash_done && !stall)
    begin
      wt <= wt + 3'h1;
      if (wt == 3'h4)
      begin
        hash_done <= 1'b1;
        wt <= 3'h0;
      end
    end
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 97000)
    begin
      failures++;
      print_verdict();
    end
  end

  ////////////////////////////////////////
  task automatic print_verdict();
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic mk(input logic [7:0] sub, input logic [7:0] slot, input logic [31:0] d,
                    input logic good, input int len);
    int so;
    int full;
    so = (sub == 8'h00) ? 36 : (sub == 8'h03) ? 16 : 8;
    full = (sub == 8'h00) ? 64 : (sub == 8'h03) ? 48 : 40;
    for (int i = 0; i < 64; i++)
      i_host.tx[i] = 8'h00; // reserved byte stays zero
    i_host.tx[0] = 8'h9B;
    i_host.tx[1] = sub;
    i_host.tx[2] = slot;
    for (int i = 0; i < 12; i++)
      i_host.tx[4 + i] = d[31 - 8 * (i % 4) -: 8];
    for (int i = 0; i < 32 && sub == 8'h00; i++)
      i_host.tx[4 + i] = kr[255 - 8 * i -: 8];
    sg = fk((sub < 8'h02) ? kr : ks, {i_host.tx[0], i_host.tx[1], i_host.tx[2], i_host.tx[3],
            i_host.tx[4], i_host.tx[5], i_host.tx[6], i_host.tx[7]}) ^ {255'h0, ~good};
    for (int i = 0; i < full - so; i++)
      i_host.tx[so + i] = sg[255 - 8 * i -: 8];
    i_host.frame((len == 0) ? full : len);
  endtask

  task automatic rd(input int n);
    for (int i = 0; i < 64; i++)
      i_host.tx[i] = 8'h00;
    i_host.tx[0] = 8'h96;
    i_host.frame(n);
  endtask

  task automatic idle();
    repeat (8) @(posedge clk);
    for (int i = 0; i < 100 && sec_busy !== 1'b0; i++)
      @(posedge clk);
  endtask

  task automatic cmd(input logic [7:0] sub, input logic [7:0] slot, input logic [31:0] d,
                     input logic good, input logic [7:0] st);
    mk(sub, slot, d, good, 0);
    idle();
    rd(3);
    chk(i_host.rx[2], st);
  endtask

  ////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    stall = 1'b0;
    hash_done = 1'b0;
    wt = 3'h0;
    kr = {8{32'hC3C3_5A5A}};
    ks = fk(kr, {8'h9B, 8'h01, 8'h00, 8'h00, 32'h1234_5678});
    rows = '{'{8'h00, 8'h00, 32'h0, 1'b1, 8'h80}, '{8'h00, 8'h00, 32'h0, 1'b1, 8'h02},
             '{8'h02, 8'h00, 32'h0, 1'b1, 8'h08}, '{8'h01, 8'h00, 32'h1234_5678, 1'b1, 8'h80},
             '{8'h02, 8'h00, 32'h0, 1'b1, 8'h80}, '{8'h02, 8'h00, 32'h0, 1'b1, 8'h10},
             '{8'h02, 8'h00, 32'h1, 1'b0, 8'h04}, '{8'h02, 8'h00, 32'h1, 1'b1, 8'h80},
             '{8'h02, 8'h05, 32'h1, 1'b1, 8'h04}, '{8'h07, 8'h00, 32'h1, 1'b1, 8'h04},
             '{8'h03, 8'h00, 32'hABCD_EF01, 1'b1, 8'h80}};
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    rd(3);
    chk(i_host.rx[2], 8'h00);
    foreach (rows[r])
    begin
      cmd(rows[r].sub, rows[r].slot, rows[r].dat, rows[r].good, rows[r].st);
      chk({4'h0, io_oe}, 8'h00);
    end
    rd(19);
    chk(i_host.rx[18], 8'h02);
    chk(i_host.rx[3], 8'hAB);
    // second command while busy must leave the counter alone
    stall = 1'b1;
    mk(8'h02, 8'h00, 32'h2, 1'b1, 0);
    repeat (8) @(posedge clk);
    chk({7'h0, sec_busy}, 8'h01);
    rd(3);
    chk(i_host.rx[2], 8'h01);
    mk(8'h02, 8'h00, 32'h2, 1'b1, 0);
    stall = 1'b0;
    idle();
    cmd(8'h02, 8'h00, 32'h3, 1'b1, 8'h80);
    mk(8'h02, 8'h00, 32'h4, 1'b1, 10);
    mk(8'h02, 8'h00, 32'h4, 1'b1, 1);
    rd(3);
    chk(i_host.rx[2], 8'h04);
    idle();
    cmd(8'h02, 8'h00, 32'h4, 1'b1, 8'h80);
    // software reset in mid operation
    stall = 1'b1;
    mk(8'h02, 8'h00, 32'h5, 1'b1, 0);
    repeat (8) @(posedge clk);
    i_host.tx[0] = 8'h66;
    i_host.frame(1);
    i_host.tx[0] = 8'h99;
    i_host.frame(1);
    repeat (8) @(posedge clk);
    chk({6'h0, sec_busy, hash_valid}, 8'h00);
    stall = 1'b0;
    rd(3);
    chk(i_host.rx[2], 8'h00);
    cmd(8'h02, 8'h00, 32'h5, 1'b1, 8'h08);
    print_verdict();
  end
endmodule
